/* File: seq_start_pkg.sv */
/*
  Package for the conversion start and channel select control.
  Holds register offsets, field positions, reset values and carrier types.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package seq_start_pkg;

  // ----------------------------------------------------------------------
  // Register map (index times four is the byte address)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  START_INDEX      = 8'h05;
  localparam logic [7:0]  CFG_INDEX        = 8'h10;
  localparam logic [7:0]  STATUS_INDEX     = 8'h11;
  localparam logic [31:0] START_ADDR       = {22'h0, START_INDEX, 2'b00};
  localparam logic [31:0] CFG_ADDR         = {22'h0, CFG_INDEX, 2'b00};
  localparam logic [31:0] STATUS_ADDR      = {22'h0, STATUS_INDEX, 2'b00};

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          SPECIAL_BIT      = 6;
  localparam int          SCAN_BIT         = 5;
  localparam int          ACROSS_BIT       = 4;
  localparam int          CODE_LSB         = 0;
  localparam int          WRAP_LSB         = 0;
  localparam int          LENGTH_LSB       = 4;
  localparam int          TRIG_EN_BIT      = 8;

  // ----------------------------------------------------------------------
  // Reset values and channel codes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  START_RESET      = 8'h00;
  localparam logic [3:0]  WRAP_RESET       = 4'hF;
  localparam logic [3:0]  LENGTH_RESET     = 4'h4;
  localparam logic [3:0]  LAST_INPUT       = 4'hB;
  localparam logic [3:0]  INPUT_SEVEN      = 4'h7;
  localparam logic [3:0]  FULL_LENGTH      = 4'hC;
  localparam logic [3:0]  CODE_INTERNAL    = 4'h1;
  localparam logic [3:0]  CODE_HIGH_REF    = 4'h4;
  localparam logic [3:0]  CODE_LOW_REF     = 4'h5;
  localparam logic [3:0]  CODE_MID_REF     = 4'h6;

  // Source handed to the converter core for one conversion
  typedef struct packed {
    logic       special;
    logic       reserved;
    logic [3:0] channel;
  } source_t;

  typedef struct packed {
    logic       special_select;
    logic       scan;
    logic       across_channels;
    logic [3:0] code;
  } start_ctl_t;

endpackage

/* File: seq_start_ctl.sv */
/*
  Conversion start and channel selection control of the sequence controller.
  Assumes the converter core pulses conv_done at the end of each conversion
  and accepts a new source whenever conv_start pulses.
*/
// Behaviour
// (RULE1) Start register write aborts and restarts
// (RULE2) External trigger armed by first write
// (RULE3) Start pulse marks first sampling phase
// (RULE4) Start register at offset five, anytime
// (RULE5) Bit six enables special channels
// (RULE6) Bit five selects single or scan
// (RULE7) Trigger mode ignores scan, one sequence
// (RULE8) Single mode holds one channel
// (RULE9) Multi mode increments over length channels
// (RULE10) Wrap channel is followed by zero
// (RULE11) Start above wrap wraps seven to zero
// (RULE12) Codes above eleven select input eleven
// (RULE13) Special codes pick internal sources
// (RULE14) Length code decoding, zero means twelve
// (RULE15) Channel tracked in internal counter
`timescale 1ns/1ps
`default_nettype none

module seq_start_ctl (
  input  wire logic                    hclk,       // Bus clock, 100 MHz
  input  wire logic                    hresetn,    // Async reset, active low
  input  wire logic                    hsel,       // AHB slave select
  input  wire logic [31:0]             haddr,      // AHB address
  input  wire logic [1:0]              htrans,     // AHB transfer type
  input  wire logic                    hwrite,     // AHB write
  input  wire logic [2:0]              hsize,      // AHB size
  input  wire logic [31:0]             hwdata,     // AHB write data
  input  wire logic                    hready,     // AHB bus ready
  output logic      [31:0]             hrdata,     // AHB read data
  output logic                         hreadyout,  // AHB slave ready
  output logic                         hresp,      // AHB response, OKAY
  input  wire logic                    ext_trigger,// External trigger event pulse
  input  wire logic                    conv_done,  // Core finished a conversion
  output logic                         conv_start, // Start of a sampling phase
  output logic                         conv_abort, // Abort running conversion
  output seq_start_pkg::source_t       source,     // Source of current conversion
  output logic                         busy        // Sequence in progress
);

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic                       wr_pend;
  logic [7:0]                 wr_index;
  seq_start_pkg::start_ctl_t  ctl;
  logic [3:0]                 wrap_channel;
  logic [3:0]                 length_code;
  logic                       ext_trigger_en;
  logic                       armed;
  logic [3:0]                 chan;
  logic [3:0]                 remaining;
  logic                       start_write;
  logic [3:0]                 seq_len;
  logic [3:0]                 next_chan;
  logic                       wrapped;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      wr_index <= 8'h00;
    end else if (hready) begin
      wr_pend  <= hsel && htrans[1] && hwrite;
      wr_index <= haddr[9:2];
    end
  end

  assign start_write = wr_pend && (wr_index == seq_start_pkg::START_INDEX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl            <= seq_start_pkg::START_RESET[6:0];
      wrap_channel   <= seq_start_pkg::WRAP_RESET;
      length_code    <= seq_start_pkg::LENGTH_RESET;
      ext_trigger_en <= 1'b0;
    end else if (wr_pend) begin
      if (wr_index == seq_start_pkg::START_INDEX) begin  // [RULE4]
        ctl <= hwdata[6:0];
      end else if (wr_index == seq_start_pkg::CFG_INDEX) begin
        wrap_channel   <= hwdata[seq_start_pkg::WRAP_LSB +: 4];
        length_code    <= hwdata[seq_start_pkg::LENGTH_LSB +: 4];
        ext_trigger_en <= hwdata[seq_start_pkg::TRIG_EN_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[9:2])
        seq_start_pkg::START_INDEX:  hrdata <= {25'h0, ctl};
        seq_start_pkg::CFG_INDEX:    hrdata <= {23'h0, ext_trigger_en, length_code,
                                                wrap_channel};
        seq_start_pkg::STATUS_INDEX: hrdata <= {22'h0, armed, busy, remaining, chan};
        default:                     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------------
  always_comb begin
    if (length_code == 4'h0 || length_code >= seq_start_pkg::FULL_LENGTH) begin
      seq_len = seq_start_pkg::FULL_LENGTH;  // [RULE14]
    end else begin
      seq_len = length_code;
    end
  end

  // Wrap at the wrap channel, or at seven while a start above it is pending
  always_comb begin
    if (!ctl.across_channels) begin
      next_chan = chan;  // [RULE8]
    end else if (!wrapped && chan == seq_start_pkg::INPUT_SEVEN) begin
      next_chan = 4'h0;  // [RULE11]
    end else if (chan == wrap_channel) begin
      next_chan = 4'h0;  // [RULE10]
    end else begin
      next_chan = chan + 4'h1;  // [RULE9]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed <= 1'b0;
    end else if (start_write) begin
      armed <= 1'b1;  // [RULE2]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy       <= 1'b0;
      chan       <= 4'h0;
      remaining  <= 4'h0;
      wrapped    <= 1'b1;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= start_write && busy;  // [RULE1]
      if (start_write && !ext_trigger_en ||
          !start_write && ext_trigger_en && armed && ext_trigger && !busy) begin
        // Field is kept; the live channel lives in the counter
        busy       <= 1'b1;
        chan       <= start_write ? hwdata[3:0] : ctl.code;  // [RULE15]
        wrapped    <= ((start_write ? hwdata[3:0] : ctl.code) <= wrap_channel);
        remaining  <= seq_len;
        conv_start <= 1'b1;  // [RULE3]
      end else if (start_write) begin
        busy <= 1'b0;  // [RULE1] [RULE2]
      end else if (busy && conv_done) begin
        if (remaining > 4'h1) begin
          remaining  <= remaining - 4'h1;
          chan       <= next_chan;
          if (next_chan == 4'h0 && ctl.across_channels) begin
            wrapped <= 1'b1;
          end
          conv_start <= 1'b1;
        end else if (ctl.scan && !ext_trigger_en) begin
          remaining  <= seq_len;  // [RULE6]
          chan       <= ctl.code;
          wrapped    <= (ctl.code <= wrap_channel);
          conv_start <= 1'b1;
        end else begin
          busy <= 1'b0;  // [RULE7]
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source decode for the analog multiplexer
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source <= '0;
    end else if (ctl.special_select) begin  // [RULE5]
      source.special  <= 1'b1;
      source.channel  <= chan;
      source.reserved <= !(chan == seq_start_pkg::CODE_INTERNAL ||
                           chan == seq_start_pkg::CODE_HIGH_REF ||
                           chan == seq_start_pkg::CODE_LOW_REF ||
                           chan == seq_start_pkg::CODE_MID_REF);  // [RULE13]
    end else begin
      source.special  <= 1'b0;
      source.reserved <= 1'b0;
      source.channel  <= (chan > seq_start_pkg::LAST_INPUT) ?
                         seq_start_pkg::LAST_INPUT : chan;  // [RULE12]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_write_restarts: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE1]
    start_write && !ext_trigger_en
    |=> conv_start && busy)
    else $error("start write did not restart sequence");

  chk_abort_pulse: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE1]
    start_write && busy
    |=> conv_abort)
    else $error("start write did not abort running sequence");

  chk_no_abort: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE1]
    !start_write
    |=> !conv_abort)
    else $error("abort without a start write");

  chk_start_stored: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE4]
    start_write
    |=> ctl == $past(hwdata[6:0]))
    else $error("start register did not take written value");

  chk_trigger_needs_arm: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE2]
    ext_trigger_en && !armed && !start_write
    |=> !conv_start)
    else $error("trigger started before arming write");

  chk_start_arms: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE2]
    start_write
    |=> armed)
    else $error("start write did not arm trigger");

  chk_trig_start: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE2]
    ext_trigger_en && armed && ext_trigger && !busy && !start_write
    |=> conv_start && busy)
    else $error("armed trigger did not start sequence");

  chk_start_busy: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE3]
    conv_start
    |-> busy)
    else $error("sampling start outside a sequence");

  chk_special_flag: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE5]
    ctl.special_select
    |=> source.special)
    else $error("special select not passed to source");

  chk_scan_repeat: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE6]
    busy && conv_done && remaining == 4'h1 && ctl.scan && !ext_trigger_en && !start_write
    |=> conv_start && busy)
    else $error("scan mode did not repeat sequence");

  chk_single_stop: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE6]
    busy && conv_done && remaining == 4'h1 && !ctl.scan && !start_write
    |=> !busy)
    else $error("single sequence did not stop");

  chk_trigger_single: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE7]
    busy && ext_trigger_en && conv_done && remaining == 4'h1 && !start_write
    |=> !busy && !conv_start)
    else $error("trigger mode repeated sequence");

  chk_single_holds: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE8]
    busy && !ctl.across_channels && !start_write
    |=> chan == $past(chan))
    else $error("single channel mode changed channel");

  chk_done_next: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE9]
    busy && conv_done && remaining > 4'h1 && !start_write
    |=> conv_start)
    else $error("next conversion not started");

  chk_chan_step: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE9]
    busy && conv_done && ctl.across_channels && remaining > 4'h1 && !start_write
    && chan != wrap_channel && !(!wrapped && chan == 4'h7)
    |=> chan == $past(chan) + 4'h1)
    else $error("channel did not increment");

  chk_wrap_zero: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE10]
    busy && conv_done && ctl.across_channels && chan == wrap_channel && wrapped
    && remaining > 4'h1 && !start_write
    |=> chan == 4'h0)
    else $error("wrap channel not followed by zero");

  chk_seven_wrap: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE11]
    busy && conv_done && ctl.across_channels && !wrapped && chan == 4'h7
    && remaining > 4'h1 && !start_write
    |=> chan == 4'h0)
    else $error("start above wrap did not wrap at seven");

  chk_code_clamp: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE12]
    !ctl.special_select && chan > 4'hB
    |=> source.channel == 4'hB)
    else $error("channel code not clamped to eleven");

  chk_reserved_ok: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE13]
    ctl.special_select && chan == 4'h1
    |=> !source.reserved)
    else $error("internal source flagged reserved");

  chk_reserved_bad: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE13]
    ctl.special_select && chan == 4'h0
    |=> source.reserved)
    else $error("reserved special code not flagged");

  chk_length_zero: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE14]
    start_write && !ext_trigger_en && length_code == 4'h0
    |=> remaining == 4'hC)
    else $error("length code zero not twelve");

  chk_field_kept: assert property (@(posedge hclk) disable iff (!hresetn)  // [RULE15]
    busy && !start_write
    |=> ctl == $past(ctl))
    else $error("start field changed during sequence");

endmodule

`default_nettype wire

/* File: conv_core_model.sv */
/*
  Behavioural model of the converter core behind the start control.
  Assumes conv_start and conv_abort are one-cycle pulses on hclk.
*/
`timescale 1ns/1ps
`default_nettype none

module conv_core_model (
  input  wire logic       hclk,       // Bus clock
  input  wire logic       hresetn,    // Async reset, active low
  input  wire logic       conv_start, // Sampling phase begins
  input  wire logic       conv_abort, // Drop running conversion
  input  wire logic [7:0] lat,        // Cycles per conversion
  output var  logic       conv_done   // End of conversion pulse
);
  // ---------------------------------------------------------------
  // Conversion timer
  // ---------------------------------------------------------------
  logic [7:0] left;

  // A new start wins over an abort in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left      <= 8'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (left == 8'h01);
      if (conv_start)
        left <= lat;
      else if (conv_abort)
        left <= 8'h00;
      else if (left != 8'h00)
        left <= left - 8'h01;
    end
  end
endmodule

`default_nettype wire

/* File: tb_top.sv */
/*
  Self-checking bench for the start and channel select control.
  Assumes zero-wait AHB-Lite slave and the behavioural core model.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] cfg;
    logic [7:0]  ctl;
    logic [3:0]  n;
    logic [47:0] seq;
    logic [1:0]  sr;
  } row_t;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic ext_trigger = 1'b0, conv_done, conv_start, conv_abort, busy;
  logic [7:0] lat = 8'h03;
  seq_start_pkg::source_t source, q[$];
  int starts, aborts, miscompares, checks;
  row_t rows[10] = '{
    '{12'h03F, 8'h13, 4'h3, 48'h543, 2'h0}, '{12'h02F, 8'h0E, 4'h2, 48'hBB, 2'h0},
    '{12'h045, 8'h14, 4'h4, 48'h1054, 2'h0}, '{12'h033, 8'h16, 4'h3, 48'h076, 2'h0},
    '{12'h00F, 8'h10, 4'hC, 48'hBA9876543210, 2'h0}, '{12'h0FF, 8'h00, 4'hC, 48'h0, 2'h0},
    '{12'h01F, 8'h41, 4'h1, 48'h1, 2'h2}, '{12'h01F, 8'h44, 4'h1, 48'h4, 2'h2},
    '{12'h01F, 8'h46, 4'h1, 48'h6, 2'h2}, '{12'h01F, 8'h40, 4'h1, 48'h0, 2'h3}};

  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  seq_start_ctl seq_start_ctl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_trigger(ext_trigger), .conv_done(conv_done), .conv_start(conv_start),
    .conv_abort(conv_abort), .source(source), .busy(busy));
  conv_core_model conv_core_model_inst (.hclk(hclk), .hresetn(hresetn),
    .conv_start(conv_start), .conv_abort(conv_abort), .lat(lat), .conv_done(conv_done));

  always @(posedge hclk) begin
    if (conv_start) starts++;
    if (conv_abort) aborts++;
    if (conv_done) q.push_back(source);
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits for hready at each phase; the bound stands in for a hung slave
  task automatic ready_edge();
    int k;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin miscompares++; summarize(); end
  endtask

  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    ready_edge();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= w ? d : 32'h0;
    ready_edge();
    rd = hrdata;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    repeat (3) @(posedge hclk);
    while (busy !== 1'b0 && k < 3000) begin @(posedge hclk); k++; end
    if (k >= 3000) begin miscompares++; summarize(); end
  endtask

  task automatic pulse();
    @(posedge hclk) ext_trigger <= 1'b1;
    @(posedge hclk) ext_trigger <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, seq_start_pkg::START_ADDR, 0); chk("start_rst", rd, 32'h0);
    foreach (rows[r]) begin
      bus(1, seq_start_pkg::CFG_ADDR, {20'h0, rows[r].cfg});
      q = {}; starts = 0;
      bus(1, seq_start_pkg::START_ADDR, {24'h0, rows[r].ctl});
      wait_idle();
      chk("starts", starts, rows[r].n == 4'h0 ? 12 : rows[r].n);
      for (int i = 0; i < rows[r].n; i++)
        chk("chan", q[i].channel, rows[r].seq[i*4+:4]);
      chk("spec_res", {q[0].special, q[0].reserved}, rows[r].sr);
    end
    lat = 8'h0A;
    bus(1, seq_start_pkg::CFG_ADDR, 32'h0F);
    bus(1, seq_start_pkg::START_ADDR, 32'h10);
    repeat (2) @(posedge hclk);
    q = {}; starts = 0; aborts = 0;
    bus(1, seq_start_pkg::START_ADDR, 32'h10);
    @(posedge hclk) chk("start_now", conv_start, 1);
    wait_idle();
    chk("aborts", aborts, 1);
    chk("restart", {q.size(), q[11].channel}, {32'hC, 4'hB});
    lat = 8'h03;
    bus(1, seq_start_pkg::CFG_ADDR, 32'h1F);
    starts = 0;
    bus(1, seq_start_pkg::START_ADDR, 32'h23);
    repeat (40) @(posedge hclk);
    chk("scan", starts > 4, 1);
    bus(1, seq_start_pkg::START_ADDR, 32'h03);
    wait_idle();
    bus(0, seq_start_pkg::START_ADDR, 0); chk("start_rd", rd[6:0], 7'h03);
    bus(1, 32'h100, 32'hFF);
    bus(0, 32'h100, 0); chk("unmapped", rd, 32'h0);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    starts = 0;
    bus(1, seq_start_pkg::CFG_ADDR, 32'h125);
    pulse(); repeat (10) @(posedge hclk);
    chk("unarmed", starts, 0);
    bus(1, seq_start_pkg::START_ADDR, 32'h25);
    repeat (10) @(posedge hclk);
    q = {};
    pulse(); wait_idle();
    chk("trig_one", starts, 2);
    chk("trig_ch", q[1].channel, 4'h5);
    pulse(); wait_idle();
    chk("trig_two", starts, 4);
    summarize();
  end
endmodule

`default_nettype wire
